// [core/hibrtc_pkg.sv]
package hibrtc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RIS = 8'h08;
    localparam logic [7:0] ADDR_IEN = 8'h0C;
    localparam logic [7:0] ADDR_ICLR = 8'h10;
    localparam logic [7:0] ADDR_CLKCFG = 8'h14;
    localparam logic [7:0] ADDR_MODE = 8'h18;
    localparam logic [7:0] ADDR_TIME = 8'h1C;
    localparam logic [7:0] ADDR_MATCH = 8'h20;
    localparam logic [7:0] ADDR_BATTHR = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_BATSTART = 0;
    localparam int CTRL_HIBREQ = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_HIBPEND = 1;
    localparam int STAT_WRBUSY = 2;
    localparam int INT_LOWBAT = 0;
    localparam int INT_MATCH = 1;
    localparam int INT_WRDONE = 2;
    localparam int NUM_INT = 3;
    localparam int CFG_OSCPD = 0;
    localparam int CFG_HIDRIVE = 1;
    localparam int CFG_LODRIVE = 2;
    localparam int CFG_SLOWOSC = 3;
    localparam int CFG_SYSCLK = 4;
    localparam int CFG_ALTCLK = 5;
    localparam int CFG_WRSTALL = 6;
    localparam int CFG_WIDTH = 7;

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [CFG_WIDTH-1:0] CLKCFG_RST = 7'h00;
    localparam logic [7:0] BATTHR_RST = 8'h80;
    localparam logic [7:0] WILDCARD = 8'hFF;
    localparam logic [31:0] MATCH_RST = 32'hFFFFFFFF;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int BATCHK_NS = 1000;
    localparam int BATCHK_CYC = (BATCHK_NS * CLK_MHZ) / 1000;
    localparam int WRDONE_NS = 50;
    localparam int WRDONE_CYC = (WRDONE_NS * CLK_MHZ) / 1000;

    typedef enum logic [1:0] {
        MODE_SECONDS,
        MODE_CAL24,
        MODE_CAL12
    } hibrtc_mode_t;

endpackage

// [core/hibrtc_cal_match.sv]
`timescale 1ns/1ps
module hibrtc_cal_match (
    // Current calendar time: day, hour, minute, second bytes
    input wire logic [31:0] calTime,
    // Match value, same layout
    input wire logic [31:0] calMatch,
    // Calendar mode active
    input wire logic calActive,
    // Result
    output logic isMatch
);
    logic [3:0] fieldHit;

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : gField
            assign fieldHit[i] = (calMatch[8*i+7:8*i] == hibrtc_pkg::WILDCARD) ||
                (calMatch[8*i+7:8*i] == calTime[8*i+7:8*i]);
        end
    endgenerate

    // With the day byte wildcarded the match recurs daily.
    assign isMatch = calActive && (&fieldHit);
endmodule

// [core/hibrtc_core.sv]
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
module hibrtc_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic busStall,
    // Battery measurement
    input wire logic [7:0] batteryLevel,
    // Calendar time from the counter
    input wire logic [31:0] calTime,
    // Oscillator and clock controls
    output logic oscPowerDown,
    output logic crystalStrongDrive,
    output logic crystalWeakDrive,
    output logic slowOscSelect,
    output logic clockOutToSystem,
    output logic clockOutAlt,
    output logic [1:0] counterMode,
    // Hibernation
    output logic hibernateGo,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic {CHK_IDLE, CHK_RUN} hibrtc_chk_t;

    hibrtc_chk_t chk_reg, chk_next;
    logic [15:0] chkCnt_reg, chkCnt_next;
    logic hibPend_reg, hibPend_next;
    logic hibGo_reg, hibGo_next;
    logic [hibrtc_pkg::NUM_INT-1:0] ris_reg, ris_next;
    logic [hibrtc_pkg::NUM_INT-1:0] ien_reg, ien_next;
    logic [hibrtc_pkg::CFG_WIDTH-1:0] cfg_reg, cfg_next;
    logic [1:0] mode_reg, mode_next;
    logic [31:0] match_reg, match_next;
    logic [7:0] thr_reg, thr_next;
    logic [7:0] wrCnt_reg, wrCnt_next;
    logic matchPrev_reg, matchPrev_next;
    logic [31:0] rdata_reg, rdata_next;
    logic calMatch;
    logic chkDone;
    logic [hibrtc_pkg::NUM_INT-1:0] evt;

    hibrtc_cal_match hibrtc_cal_match_i (
        .calTime(calTime),
        .calMatch(match_reg),
        .calActive(mode_reg != 2'(hibrtc_pkg::MODE_SECONDS)),
        .isMatch(calMatch)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        chk_next = chk_reg;
        chkCnt_next = chkCnt_reg;
        hibPend_next = hibPend_reg;
        hibGo_next = 1'b0;
        ien_next = ien_reg;
        cfg_next = cfg_reg;
        mode_next = mode_reg;
        match_next = match_reg;
        thr_next = thr_reg;
        wrCnt_next = (wrCnt_reg != 8'h00) ? wrCnt_reg - 8'h01 : 8'h00;
        matchPrev_next = calMatch;
        chkDone = 1'b0;
        evt = '0;
        case (chk_reg)
            CHK_IDLE: begin
                if (regWrite && regAddr == hibrtc_pkg::ADDR_CTRL &&
                    regWdata[hibrtc_pkg::CTRL_BATSTART]) begin
                    chk_next = CHK_RUN;
                    chkCnt_next = 16'(hibrtc_pkg::BATCHK_CYC - 1);
                end
            end
            CHK_RUN: begin
                if (chkCnt_reg == 16'h0000) begin
                    chk_next = CHK_IDLE;
                    chkDone = 1'b1;
                end else begin
                    chkCnt_next = chkCnt_reg - 16'h0001;
                end
            end
            default: chk_next = CHK_IDLE;
        endcase
        evt[hibrtc_pkg::INT_LOWBAT] = chkDone && (batteryLevel < thr_reg);
        evt[hibrtc_pkg::INT_MATCH] = calMatch && !matchPrev_reg;
        evt[hibrtc_pkg::INT_WRDONE] = (wrCnt_reg == 8'h01);
        if (regWrite) begin
            wrCnt_next = 8'(hibrtc_pkg::WRDONE_CYC);
            case (regAddr)
                hibrtc_pkg::ADDR_CTRL: begin
                    if (regWdata[hibrtc_pkg::CTRL_HIBREQ]) hibPend_next = 1'b1;
                end
                hibrtc_pkg::ADDR_IEN: ien_next = regWdata[hibrtc_pkg::NUM_INT-1:0];
                hibrtc_pkg::ADDR_CLKCFG: begin
                    cfg_next = regWdata[hibrtc_pkg::CFG_WIDTH-1:0];
                    // Strong and weak drive are exclusive; strong wins.
                    if (regWdata[hibrtc_pkg::CFG_HIDRIVE]) begin
                        cfg_next[hibrtc_pkg::CFG_LODRIVE] = 1'b0;
                    end
                end
                hibrtc_pkg::ADDR_MODE: begin
                    // Undefined codes fall back to the seconds counter.
                    if (regWdata[1:0] == 2'(hibrtc_pkg::MODE_CAL24) ||
                        regWdata[1:0] == 2'(hibrtc_pkg::MODE_CAL12)) begin
                        mode_next = regWdata[1:0];
                    end else begin
                        mode_next = 2'(hibrtc_pkg::MODE_SECONDS);
                    end
                end
                hibrtc_pkg::ADDR_MATCH: match_next = regWdata;
                hibrtc_pkg::ADDR_BATTHR: thr_next = regWdata[7:0];
                default: ;
            endcase
        end
        if (hibPend_reg && chk_reg == CHK_IDLE) begin
            hibPend_next = 1'b0;
            hibGo_next = 1'b1;
        end
        ris_next = ris_reg;
        if (regWrite && regAddr == hibrtc_pkg::ADDR_ICLR) begin
            ris_next = ris_reg & ~regWdata[hibrtc_pkg::NUM_INT-1:0];
        end
        ris_next = ris_next | evt;
        rdata_next = 32'h00000000;
        if (regRead) begin
            case (regAddr)
                hibrtc_pkg::ADDR_CTRL: rdata_next = 32'h00000000;
                hibrtc_pkg::ADDR_STATUS: begin
                    rdata_next[hibrtc_pkg::STAT_BUSY] = (chk_reg == CHK_RUN);
                    rdata_next[hibrtc_pkg::STAT_HIBPEND] = hibPend_reg;
                    rdata_next[hibrtc_pkg::STAT_WRBUSY] = (wrCnt_reg != 8'h00);
                end
                hibrtc_pkg::ADDR_RIS: rdata_next[hibrtc_pkg::NUM_INT-1:0] = ris_reg;
                hibrtc_pkg::ADDR_IEN: rdata_next[hibrtc_pkg::NUM_INT-1:0] = ien_reg;
                hibrtc_pkg::ADDR_CLKCFG: rdata_next[hibrtc_pkg::CFG_WIDTH-1:0] = cfg_reg;
                hibrtc_pkg::ADDR_MODE: rdata_next[1:0] = mode_reg;
                hibrtc_pkg::ADDR_TIME: rdata_next = calTime;
                hibrtc_pkg::ADDR_MATCH: rdata_next = match_reg;
                hibrtc_pkg::ADDR_BATTHR: rdata_next[7:0] = thr_reg;
                default: rdata_next = 32'h00000000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            chk_reg <= CHK_IDLE;
            chkCnt_reg <= 16'h0000;
            hibPend_reg <= 1'b0;
            hibGo_reg <= 1'b0;
            ris_reg <= '0;
            ien_reg <= '0;
            cfg_reg <= hibrtc_pkg::CLKCFG_RST;
            mode_reg <= 2'(hibrtc_pkg::MODE_SECONDS);
            match_reg <= hibrtc_pkg::MATCH_RST;
            thr_reg <= hibrtc_pkg::BATTHR_RST;
            wrCnt_reg <= 8'h00;
            matchPrev_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            chk_reg <= chk_next;
            chkCnt_reg <= chkCnt_next;
            hibPend_reg <= hibPend_next;
            hibGo_reg <= hibGo_next;
            ris_reg <= ris_next;
            ien_reg <= ien_next;
            cfg_reg <= cfg_next;
            mode_reg <= mode_next;
            match_reg <= match_next;
            thr_reg <= thr_next;
            wrCnt_reg <= wrCnt_next;
            matchPrev_reg <= matchPrev_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdata = rdata_reg;
    assign irq = |(ris_reg & ien_reg);
    assign oscPowerDown = cfg_reg[hibrtc_pkg::CFG_OSCPD];
    assign crystalStrongDrive = cfg_reg[hibrtc_pkg::CFG_HIDRIVE];
    assign crystalWeakDrive = cfg_reg[hibrtc_pkg::CFG_LODRIVE];
    assign slowOscSelect = cfg_reg[hibrtc_pkg::CFG_SLOWOSC];
    assign clockOutToSystem = cfg_reg[hibrtc_pkg::CFG_SYSCLK];
    assign clockOutAlt = cfg_reg[hibrtc_pkg::CFG_ALTCLK];
    // The stall holds while a write is still settling.
    assign busStall = cfg_reg[hibrtc_pkg::CFG_WRSTALL] && (wrCnt_reg != 8'h00);
    assign counterMode = mode_reg;
    assign hibernateGo = hibGo_reg;
endmodule

// [testbench/hibrtc_core_monitor.sv]
`timescale 1ns/1ps
module hibrtc_core_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic busStall,
    // Sensors and controls
    input wire logic [7:0] batteryLevel,
    input wire logic [31:0] calTime,
    input wire logic oscPowerDown,
    input wire logic crystalStrongDrive,
    input wire logic crystalWeakDrive,
    input wire logic slowOscSelect,
    input wire logic clockOutToSystem,
    input wire logic clockOutAlt,
    input wire logic [1:0] counterMode,
    input wire logic hibernateGo,
    input wire logic irq
);
    // ----------------------------------------
    // Port checks
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic cfgWr;
    logic [1:0] modeIn;
    assign cfgWr = regWrite && regAddr == hibrtc_pkg::ADDR_CLKCFG;
    assign modeIn = (regWdata[1:0] == 2'h3) ? 2'h0 : regWdata[1:0];
    chk_read_idle: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data not zero outside a read");
    chk_time_read: assert property (regRead && regAddr == hibrtc_pkg::ADDR_TIME
        |=> regRdata == $past(calTime)) else $error("time read mismatch");
    chk_osc_cfg: assert property (cfgWr |=> oscPowerDown == $past(regWdata[0])
        && slowOscSelect == $past(regWdata[3])) else $error("oscillator setting wrong");
    chk_drive_sel: assert property (cfgWr |=> crystalStrongDrive == $past(regWdata[1])
        && crystalWeakDrive == ($past(regWdata[2]) && !$past(regWdata[1])))
        else $error("drive setting wrong");
    chk_clock_out: assert property (cfgWr |=> clockOutToSystem == $past(regWdata[4])
        && clockOutAlt == $past(regWdata[5])) else $error("clock output setting wrong");
    chk_stall_src: assert property ($rose(busStall) |-> ($past(regWrite) || regWrite)
        ##1 busStall ##[1:8] !busStall) else $error("stall not tied to a write");
    chk_hib_pulse: assert property (hibernateGo |=> !hibernateGo)
        else $error("hibernate pulse too long");
    chk_mode_legal: assert property (counterMode != 2'h3)
        else $error("illegal counter mode");
    chk_mode_write: assert property (regWrite && regAddr == hibrtc_pkg::ADDR_MODE
        |=> counterMode == $past(modeIn)) else $error("counter mode not written");
endmodule

bind hibrtc_core hibrtc_core_monitor hibrtc_core_monitor_i (.clk, .rst_n, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .busStall, .batteryLevel, .calTime,
    .oscPowerDown, .crystalStrongDrive, .crystalWeakDrive, .slowOscSelect,
    .clockOutToSystem, .clockOutAlt, .counterMode, .hibernateGo, .irq);

// [testbench/hibrtc_core_tb_top.sv]
`timescale 1ns/1ps
module hibrtc_core_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] batteryLevel = 8'h00;
    logic [31:0] calTime = 32'h0;
    logic [31:0] regRdata, v;
    logic busStall, oscPowerDown, crystalStrongDrive, crystalWeakDrive, slowOscSelect;
    logic clockOutToSystem, clockOutAlt, hibernateGo, irq;
    logic [1:0] counterMode;
    logic [7:0] hibCount = 8'h00;
    logic [7:0] hibBase;
    logic [7:0] lvl, thr;
    logic [6:0] w;
    int nErrors = 0;
    int checksDone = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (hibernateGo === 1'b1) hibCount <= hibCount + 8'h01;

    hibrtc_core hibrtc_core_i (.clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .busStall, .batteryLevel, .calTime, .oscPowerDown, .crystalStrongDrive,
        .crystalWeakDrive, .slowOscSelect, .clockOutToSystem, .clockOutAlt, .counterMode,
        .hibernateGo, .irq);

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    function automatic logic [5:0] cfgExp(input logic [6:0] c);
        return {c[5], c[4], c[3], c[2] & ~c[1], c[1], c[0]};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            nErrors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk($sformatf("register %h", a), e, d);
    endtask
    task automatic closeOut;
        $display("Errors %0d in %0d checks", nErrors, checksDone);
        if (nErrors == 0 && checksDone > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        void'($urandom(39763));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rc(hibrtc_pkg::ADDR_BATTHR, 32'h80);
        rc(hibrtc_pkg::ADDR_MATCH, 32'hFFFFFFFF);
        rc(8'h3C, 32'h0);
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 7'h06 : (i == 1) ? 7'h3F : 7'($urandom % 64);
            wr(hibrtc_pkg::ADDR_CLKCFG, {25'h0, w});
            v = {26'h0, clockOutAlt, clockOutToSystem, slowOscSelect, crystalWeakDrive,
                crystalStrongDrive, oscPowerDown};
            chk("clock config", {26'h0, cfgExp(w)}, v);
        end
        for (int j = 0; j < 4; j++) begin
            lvl = (j == 0) ? 8'h7F : (j == 1) ? 8'h80 : 8'($urandom);
            thr = (j < 2) ? hibrtc_pkg::BATTHR_RST : 8'($urandom);
            @(posedge clk);
            batteryLevel <= lvl;
            wr(hibrtc_pkg::ADDR_BATTHR, {24'h0, thr});
            rc(hibrtc_pkg::ADDR_BATTHR, {24'h0, thr});
            wr(hibrtc_pkg::ADDR_ICLR, 32'h7);
            wr(hibrtc_pkg::ADDR_IEN, 32'h1);
            hibBase = hibCount;
            wr(hibrtc_pkg::ADDR_CTRL, 32'h1);
            wr(hibrtc_pkg::ADDR_CTRL, 32'h2);
            rd(hibrtc_pkg::ADDR_STATUS, v);
            chk("check running", 32'h3, v & 32'h3);
            for (int k = 0; k < 200 && v[0] !== 1'b0; k++) begin
                chk("hibernate held", {24'h0, hibBase}, {24'h0, hibCount});
                rd(hibrtc_pkg::ADDR_STATUS, v);
            end
            if (v[0] !== 1'b0) begin
                nErrors++;
                closeOut();
            end
            repeat (3) @(posedge clk);
            #1;
            chk("hibernate go", {24'h0, hibBase + 8'h01}, {24'h0, hibCount});
            rd(hibrtc_pkg::ADDR_RIS, v);
            chk("low flag", {31'h0, lvl < thr}, v & 32'h1);
            chk("irq", {31'h0, lvl < thr}, irq);
            wr(hibrtc_pkg::ADDR_IEN, 32'h0);
            chk("irq masked", 32'h0, irq);
            wr(hibrtc_pkg::ADDR_ICLR, 32'h7);
            rc(hibrtc_pkg::ADDR_RIS, 32'h0);
        end
        wr(hibrtc_pkg::ADDR_CLKCFG, 32'h40);
        repeat (8) @(posedge clk);
        wr(hibrtc_pkg::ADDR_IEN, 32'h0);
        chk("stall", 32'h1, busStall);
        repeat (8) @(posedge clk);
        #1;
        chk("stall end", 32'h0, busStall);
        wr(hibrtc_pkg::ADDR_CLKCFG, 32'h0);
        repeat (8) @(posedge clk);
        wr(hibrtc_pkg::ADDR_IEN, 32'h0);
        chk("no stall", 32'h0, busStall);
        rd(hibrtc_pkg::ADDR_STATUS, v);
        chk("write busy", 32'h4, v & 32'h4);
        for (int m = 0; m < 4; m++) begin
            wr(hibrtc_pkg::ADDR_MODE, m);
            chk("mode", (m == 3) ? 0 : m, counterMode);
        end
        wr(hibrtc_pkg::ADDR_MODE, 32'h1);
        wr(hibrtc_pkg::ADDR_MATCH, 32'hFF0A141E);
        wr(hibrtc_pkg::ADDR_ICLR, 32'h7);
        for (int d = 0; d < 3; d++) begin
            @(posedge clk);
            calTime <= {8'($urandom), 24'h0A141E};
            repeat (3) @(posedge clk);
            rc(hibrtc_pkg::ADDR_TIME, calTime);
            rd(hibrtc_pkg::ADDR_RIS, v);
            chk("daily match", 32'h2, v & 32'h2);
            @(posedge clk);
            calTime <= {8'($urandom), 24'h0A141F};
            wr(hibrtc_pkg::ADDR_ICLR, 32'h7);
            rd(hibrtc_pkg::ADDR_RIS, v);
            chk("near miss", 32'h0, v & 32'h2);
        end
        wr(hibrtc_pkg::ADDR_MODE, 32'h0);
        @(posedge clk);
        calTime <= 32'h050A141E;
        repeat (3) @(posedge clk);
        rd(hibrtc_pkg::ADDR_RIS, v);
        chk("seconds mode", 32'h0, v & 32'h2);
        closeOut();
    end
endmodule
